// file: verilog/mfc_feature_page.sv
// Purpose: Motion feature configuration page with APB access, axis remap and any-motion detection.
// Assumes: Sensor samples are synchronous to pclk; registers sit at byte address four times their index.
// Notes:   Zero wait states; reads are captured in the setup cycle.
//
// Overview of operation
// - General bit 2 negates the x axis output; reset clear.
// - Y source field picks x, y or z; code 3 acts as y; reset y.
// - General bit 5 negates the y axis output.
// - Z source field picks x, y or z; code 3 acts as z; reset z.
// - General bit 8 negates the z axis output.
// - With bit 9 set the device writes the gyroscope offset registers itself.
// - General bit 10 prepares the system for memory programming; reset clear.
// - Each axis gain ratio is an eleven bit Q1.10 value, 0.75 to 1.25.
// - Writing one to z gain bit 11 starts the update; device clears it when done.
// - Any-motion duration counts consecutive 20 ms samples before the event; default 5.
// - Any-motion bits 13 to 15 select x, y and z; all set at reset.
// - Any-motion slope threshold field, bits 10 to 0, default 0xaa.
// - Four-bit routing field picks the status bit for the result; reset 7.
// - Any-motion words reset to 0xe005 and 0x38aa; gain words reset to zero.
// - Routing code 0 routes nowhere; codes 1 to 8 route to bits 0 to 7.
`timescale 1ns/1ps

module mfc_feature_page
    import mfc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = (`MFC_SAMPLE_MS * 1000000) / (`MFC_CLK_PS / 1000)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] sensor_x,
    input  wire logic [15:0] sensor_y,
    input  wire logic [15:0] sensor_z,
    output logic      [15:0] axis_out_x,
    output logic      [15:0] axis_out_y,
    output logic      [15:0] axis_out_z,
    input  wire logic        offset_corr_valid,
    input  wire logic [15:0] offset_corr_x,
    input  wire logic [15:0] offset_corr_y,
    input  wire logic [15:0] offset_corr_z,
    output logic             self_offset_enable,
    output logic             nvm_prog_prep,
    output logic      [10:0] gain_ratio_x,
    output logic      [10:0] gain_ratio_y,
    output logic      [10:0] gain_ratio_z,
    output logic             gain_upd_start,
    input  wire logic        gain_upd_done,
    output logic      [7:0]  feat_int_status,
    output logic             irq
);

    mfc_state_s r;
    mfc_state_s n;

    // A reserved source code keeps the axis on its own default source.
    function automatic logic [1:0] eff_sel(input logic [1:0] sel, input logic [1:0] dflt);
        if (sel == `MFC_AXIS_RSV) begin
            eff_sel = dflt;
        end else begin
            eff_sel = sel;
        end
    endfunction

    function automatic logic [15:0] pick(input logic [1:0]  sel,
                                         input logic [15:0] x,
                                         input logic [15:0] y,
                                         input logic [15:0] z);
        case (sel)
            `MFC_AXIS_X: pick = x;
            `MFC_AXIS_Y: pick = y;
            default:     pick = z;
        endcase
    endfunction

    // Two's complement negation; the most negative sample maps onto itself.
    function automatic logic [15:0] cond_neg(input logic [15:0] v, input logic inv);
        if (inv) begin
            cond_neg = 16'h0000 - v;
        end else begin
            cond_neg = v;
        end
    endfunction

    // The difference is taken signed and its magnitude returned unsigned.
    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        if ($signed(a) >= $signed(b)) begin
            abs_diff = a - b;
        end else begin
            abs_diff = b - a;
        end
    endfunction

    // The threshold meets the raw slope with no scaling to g, so users must scale it themselves.
    function automatic logic slope_hit(input logic [15:0]               cur,
                                       input logic [15:0]               prev,
                                       input logic [`MFC_AM_THR_W-1:0] thr);
        slope_hit = abs_diff(cur, prev) > {5'h00, thr};
    endfunction

    // Code 0 routes nowhere; reserved codes above the last bit act as the default code.
    function automatic logic [7:0] route_vec(input logic [3:0] code);
        logic [3:0] eff;
        eff = (code > `MFC_ROUTE_LAST) ? `MFC_ROUTE_DEF : code;
        route_vec = 8'h00;
        if (eff != `MFC_ROUTE_OFF) begin
            route_vec[3'(eff - 4'h1)] = 1'b1;
        end
    endfunction

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [15:0] m, input logic [1:0] strb);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & m;
        wmerge = (old & ~lanes) | (wd & lanes);
    endfunction

    // Returns the hit flag above the read word; unmapped or unaligned addresses miss.
    function automatic logic [16:0] decode(input mfc_state_s s, input logic [31:0] a);
        logic [`MFC_IDX_W-1:0] idx;
        logic                  ok;
        idx = a[`MFC_IDX_W+1:2];
        ok  = (a[1:0] == 2'h0) && (a[31:`MFC_IDX_W+2] == '0);
        decode = 17'h00000;
        if (ok) begin
            unique case (idx)
                `MFC_IDX_GEN:      decode = {1'b1, s.gen};
                `MFC_IDX_GAIN_X:   decode = {1'b1, s.gain_x};
                `MFC_IDX_GAIN_Y:   decode = {1'b1, s.gain_y};
                `MFC_IDX_GAIN_Z:   decode = {1'b1, s.gain_z};
                `MFC_IDX_AM1:      decode = {1'b1, s.am1};
                `MFC_IDX_AM2:      decode = {1'b1, s.am2};
                `MFC_IDX_INT_STAT: decode = {1'b1, 13'h0000, s.int_stat};
                `MFC_IDX_INT_MASK: decode = {1'b1, 13'h0000, s.int_mask};
                `MFC_IDX_OFF_X:    decode = {1'b1, s.off_x};
                `MFC_IDX_OFF_Y:    decode = {1'b1, s.off_y};
                `MFC_IDX_OFF_Z:    decode = {1'b1, s.off_z};
                default:           decode = 17'h00000;
            endcase
        end
    endfunction

    logic [16:0]              rd;
    logic                     wr;
    logic [`MFC_IDX_W-1:0]    widx;
    logic [15:0]              wd;
    logic [1:0]               ws;
    logic                     tick;
    logic [2:0]               over;
    logic                     hit_any;
    logic [`MFC_AM_DUR_W-1:0] dur;
    logic [`MFC_AM_DUR_W-1:0] cnt_nxt;
    logic                     am_event;
    logic [3:0]               route;
    logic [`MFC_NUM_EV-1:0]   ev;

    always_comb begin
        n        = r;
        rd       = decode(r, paddr);
        wr       = psel && penable && pwrite && rd[16];
        widx     = paddr[`MFC_IDX_W+1:2];
        wd       = pwdata[15:0];
        ws       = pstrb[1:0];
        ev       = '0;
        am_event = 1'b0;
        over     = 3'h0;
        hit_any  = 1'b0;
        cnt_nxt  = '0;
        route    = r.am2[`MFC_AM_ROUTE +: 4];
        dur      = r.am1[`MFC_AM_DUR_W-1:0];
        n.feat_int = 8'h00;

        // Read data and the error answer are settled in the setup cycle.
        if (psel && !penable) begin
            n.prdata = {16'h0000, rd[15:0]};
            n.slverr = !rd[16];
        end

        // The device clears the start bit once the gain update is done.
        if (gain_upd_done && r.gain_z[`MFC_GAIN_START]) begin
            n.gain_z[`MFC_GAIN_START] = 1'b0;
            ev[`MFC_EV_GAIN] = 1'b1;
        end

        if (wr) begin
            unique case (widx)
                `MFC_IDX_GEN:      n.gen    = wmerge(r.gen, wd, `MFC_MASK_GEN, ws);
                `MFC_IDX_GAIN_X:   n.gain_x = wmerge(r.gain_x, wd, `MFC_MASK_RATIO, ws);
                `MFC_IDX_GAIN_Y:   n.gain_y = wmerge(r.gain_y, wd, `MFC_MASK_RATIO, ws);
                `MFC_IDX_GAIN_Z:   n.gain_z = wmerge(n.gain_z, wd, `MFC_MASK_GAIN_Z, ws);
                `MFC_IDX_AM1:      n.am1    = wmerge(r.am1, wd, `MFC_MASK_FULL, ws);
                `MFC_IDX_AM2:      n.am2    = wmerge(r.am2, wd, `MFC_MASK_FULL, ws);
                `MFC_IDX_INT_STAT: n.int_stat = r.int_stat & ~(wd[`MFC_NUM_EV-1:0] & {`MFC_NUM_EV{ws[0]}});
                `MFC_IDX_INT_MASK: n.int_mask = ws[0] ? wd[`MFC_NUM_EV-1:0] : r.int_mask;
                `MFC_IDX_OFF_X:    n.off_x  = wmerge(r.off_x, wd, `MFC_MASK_FULL, ws);
                `MFC_IDX_OFF_Y:    n.off_y  = wmerge(r.off_y, wd, `MFC_MASK_FULL, ws);
                `MFC_IDX_OFF_Z:    n.off_z  = wmerge(r.off_z, wd, `MFC_MASK_FULL, ws);
                default:           n.gen    = r.gen;
            endcase
        end

        // The device's own offset update is applied after a host write, so it wins.
        if (r.gen[`MFC_GEN_SELF_OFF] && offset_corr_valid) begin
            n.off_x = offset_corr_x;
            n.off_y = offset_corr_y;
            n.off_z = offset_corr_z;
            ev[`MFC_EV_OFF] = 1'b1;
        end

        // Remapped and sign corrected axes.
        n.out_x = cond_neg(pick(eff_sel(r.gen[`MFC_GEN_XSEL +: 2], `MFC_AXIS_X), sensor_x, sensor_y, sensor_z),
                           r.gen[`MFC_GEN_XSIGN]);
        n.out_y = cond_neg(pick(eff_sel(r.gen[`MFC_GEN_YSEL +: 2], `MFC_AXIS_Y), sensor_x, sensor_y, sensor_z),
                           r.gen[`MFC_GEN_YSIGN]);
        n.out_z = cond_neg(pick(eff_sel(r.gen[`MFC_GEN_ZSEL +: 2], `MFC_AXIS_Z), sensor_x, sensor_y, sensor_z),
                           r.gen[`MFC_GEN_ZSIGN]);

        // The 20 ms sample tick free-runs so that detection stays on a fixed grid.
        tick = (r.tick_cnt == 32'(SAMPLE_CYCLES - 1));
        n.tick_cnt = tick ? 32'h00000000 : r.tick_cnt + 32'h00000001;

        if (tick) begin
            n.prev_x = sensor_x;
            n.prev_y = sensor_y;
            n.prev_z = sensor_z;
            // Slope per axis against the threshold, selected axes only.
            over[0] = slope_hit(sensor_x, r.prev_x, r.am2[`MFC_AM_THR_W-1:0]);
            over[1] = slope_hit(sensor_y, r.prev_y, r.am2[`MFC_AM_THR_W-1:0]);
            over[2] = slope_hit(sensor_z, r.prev_z, r.am2[`MFC_AM_THR_W-1:0]);
            hit_any = |(over & r.am1[`MFC_AM_SEL_X +: 3]);
            if (r.am2[`MFC_AM_EN] && hit_any) begin
                // Consecutive samples saturate; the event fires once as the count reaches a duration below all ones, and on every saturated sample at all ones.
                cnt_nxt  = (&r.am_cnt) ? r.am_cnt : r.am_cnt + 13'h0001;
                am_event = (cnt_nxt == ((dur == '0) ? 13'h0001 : dur));
            end
            n.am_cnt = cnt_nxt;
        end

        if (am_event) begin
            ev[`MFC_EV_AM] = 1'b1;
            // Reserved routing codes above 8 fall back to the default code.
            n.feat_int = route_vec(route);
        end

        // Set wins over a same-cycle write-one-to-clear.
        n.int_stat = n.int_stat | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.gen      <= `MFC_RST_GEN;
            r.gain_x   <= `MFC_RST_ZERO;
            r.gain_y   <= `MFC_RST_ZERO;
            r.gain_z   <= `MFC_RST_ZERO;
            r.am1      <= `MFC_RST_AM1;
            r.am2      <= `MFC_RST_AM2;
        end else begin
            r <= n;
        end
    end

    assign prdata             = r.prdata;
    assign pready             = psel && penable;
    assign pslverr            = psel && penable && r.slverr;
    assign axis_out_x         = r.out_x;
    assign axis_out_y         = r.out_y;
    assign axis_out_z         = r.out_z;
    assign self_offset_enable = r.gen[`MFC_GEN_SELF_OFF];
    assign nvm_prog_prep      = r.gen[`MFC_GEN_NVM_PREP];
    assign gain_ratio_x       = r.gain_x[`MFC_RATIO_W-1:0];
    assign gain_ratio_y       = r.gain_y[`MFC_RATIO_W-1:0];
    assign gain_ratio_z       = r.gain_z[`MFC_RATIO_W-1:0];
    assign gain_upd_start     = r.gain_z[`MFC_GAIN_START];
    assign feat_int_status    = r.feat_int;
    assign irq                = |(r.int_stat & r.int_mask);

endmodule

// file: verilog/mfc_regs.svh
// Purpose: Register indices, field positions, reset values and timing figures of the feature page.
// Assumes: The byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH

`define MFC_IDX_W        7
`define MFC_IDX_GEN      7'h34
`define MFC_IDX_GAIN_X   7'h36
`define MFC_IDX_GAIN_Y   7'h38
`define MFC_IDX_GAIN_Z   7'h3a
`define MFC_IDX_AM1      7'h3c
`define MFC_IDX_AM2      7'h3e
`define MFC_IDX_INT_STAT 7'h40
`define MFC_IDX_INT_MASK 7'h42
`define MFC_IDX_OFF_X    7'h44
`define MFC_IDX_OFF_Y    7'h46
`define MFC_IDX_OFF_Z    7'h48

`define MFC_RST_GEN      16'h0088
`define MFC_RST_ZERO     16'h0000
`define MFC_RST_AM1      16'he005
`define MFC_RST_AM2      16'h38aa

`define MFC_MASK_GEN     16'h07ff
`define MFC_MASK_RATIO   16'h07ff
`define MFC_MASK_GAIN_Z  16'h0fff
`define MFC_MASK_FULL    16'hffff

`define MFC_GEN_XSEL     0
`define MFC_GEN_XSIGN    2
`define MFC_GEN_YSEL     3
`define MFC_GEN_YSIGN    5
`define MFC_GEN_ZSEL     6
`define MFC_GEN_ZSIGN    8
`define MFC_GEN_SELF_OFF 9
`define MFC_GEN_NVM_PREP 10
`define MFC_RATIO_W      11
`define MFC_GAIN_START   11

`define MFC_AM_DUR_W     13
`define MFC_AM_SEL_X     13
`define MFC_AM_THR_W     11
`define MFC_AM_ROUTE     11
`define MFC_AM_EN        15

`define MFC_AXIS_X       2'h0
`define MFC_AXIS_Y       2'h1
`define MFC_AXIS_Z       2'h2
`define MFC_AXIS_RSV     2'h3

`define MFC_ROUTE_OFF    4'h0
`define MFC_ROUTE_LAST   4'h8
`define MFC_ROUTE_DEF    4'h7

`define MFC_NUM_EV       3
`define MFC_EV_AM        0
`define MFC_EV_GAIN      1
`define MFC_EV_OFF       2

`define MFC_SAMPLE_MS    20
`define MFC_CLK_PS       5000

`endif

// file: verilog/mfc_pkg.sv
// Purpose: Types shared by the feature page.
// Assumes: mfc_regs.svh supplies the event and duration-count widths; word, tick, routing and read widths are literal.
// Notes:   The whole block state is one packed struct.
`include "mfc_regs.svh"

package mfc_pkg;

    typedef logic [15:0] mfc_word_t;

    typedef struct packed {
        mfc_word_t                  gen;
        mfc_word_t                  gain_x;
        mfc_word_t                  gain_y;
        mfc_word_t                  gain_z;
        mfc_word_t                  am1;
        mfc_word_t                  am2;
        mfc_word_t                  off_x;
        mfc_word_t                  off_y;
        mfc_word_t                  off_z;
        logic [`MFC_NUM_EV-1:0]     int_stat;
        logic [`MFC_NUM_EV-1:0]     int_mask;
        mfc_word_t                  prev_x;
        mfc_word_t                  prev_y;
        mfc_word_t                  prev_z;
        logic [`MFC_AM_DUR_W-1:0]   am_cnt;
        logic [31:0]                tick_cnt;
        mfc_word_t                  out_x;
        mfc_word_t                  out_y;
        mfc_word_t                  out_z;
        logic [7:0]                 feat_int;
        logic [31:0]                prdata;
        logic                       slverr;
    } mfc_state_s;

endpackage

// file: tb/mfc_feature_page_props.sv
// Purpose: Concurrent checks on the ports of the feature page.
// Assumes: A register's byte address is four times its index.
// Notes:   Bound to every instance of the page.
`timescale 1ns/1ps
`include "mfc_regs.svh"

module mfc_page_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [31:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        self_offset_enable,
    input wire logic        nvm_prog_prep,
    input wire logic        gain_upd_start,
    input wire logic        gain_upd_done,
    input wire logic [7:0]  feat_int_status,
    input wire logic        irq
);
    localparam logic [31:0] A_GEN = {23'h0, `MFC_IDX_GEN, 2'b00};
    localparam logic [31:0] A_GZ  = {23'h0, `MFC_IDX_GAIN_Z, 2'b00};
    logic acc;
    logic wr_gen;
    logic start_wr;
    assign acc      = psel && penable;
    assign wr_gen   = acc && pwrite && paddr == A_GEN && pstrb[1];
    assign start_wr = acc && pwrite && paddr == A_GZ && pstrb[1] && pwdata[11];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_unaligned_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    chk_err_no_data: assert property (acc && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper half of read data not zero");
    chk_self_off_bit: assert property (wr_gen |=> self_offset_enable == $past(pwdata[9]))
        else $error("self offset enable does not follow written bit");
    chk_nvm_prep_bit: assert property (wr_gen |=> nvm_prog_prep == $past(pwdata[10]))
        else $error("programming prepare does not follow written bit");
    chk_gain_start_set: assert property (start_wr |=> gain_upd_start)
        else $error("gain update start not raised by write");
    chk_gain_done_clr: assert property (gain_upd_start && gain_upd_done && !start_wr |=> !gain_upd_start)
        else $error("gain update start not cleared on done");
    chk_gain_no_self: assert property (!gain_upd_start && !start_wr |=> !gain_upd_start)
        else $error("gain update start rose without a write");
    chk_route_onehot: assert property ($onehot0(feat_int_status))
        else $error("more than one routed status bit");
    chk_event_pulse: assert property (feat_int_status != 8'h0 |=> feat_int_status == 8'h0)
        else $error("detection pulse longer than one cycle");
    cov_gain_done: cover property (gain_upd_start && gain_upd_done);
    cov_motion: cover property (feat_int_status != 8'h0);
    cov_irq: cover property ($rose(irq));
endmodule

bind mfc_feature_page mfc_page_props u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .self_offset_enable(self_offset_enable), .nvm_prog_prep(nvm_prog_prep), .gain_upd_start(gain_upd_start),
    .gain_upd_done(gain_upd_done), .feat_int_status(feat_int_status), .irq(irq));

// file: tb/tb_mfc_feature_page.sv
// Purpose: Self-checking bench for the motion feature configuration page.
// Assumes: Sample tick shortened to 8 clocks so detection runs in a few hundred cycles.
// Notes:   Sensor x ramps only during the any-motion test, so remap rows see fixed samples.
`timescale 1ns/1ps
`include "mfc_regs.svh"

module tb_mfc_feature_page import mfc_pkg::*;;
    typedef struct packed {logic [31:0] a; logic [15:0] w, r, ox, oy, oz;} mfc_row_s;
    localparam logic [31:0] A_GEN = {23'h0, `MFC_IDX_GEN, 2'b00};
    localparam logic [31:0] A_GX  = {23'h0, `MFC_IDX_GAIN_X, 2'b00};
    localparam logic [31:0] A_GY  = {23'h0, `MFC_IDX_GAIN_Y, 2'b00};
    localparam logic [31:0] A_GZ  = {23'h0, `MFC_IDX_GAIN_Z, 2'b00};
    localparam logic [31:0] A_AM1 = {23'h0, `MFC_IDX_AM1, 2'b00};
    localparam logic [31:0] A_AM2 = {23'h0, `MFC_IDX_AM2, 2'b00};
    localparam logic [31:0] A_ST  = {23'h0, `MFC_IDX_INT_STAT, 2'b00};
    localparam logic [31:0] A_MK  = {23'h0, `MFC_IDX_INT_MASK, 2'b00};
    localparam logic [31:0] A_OX  = {23'h0, `MFC_IDX_OFF_X, 2'b00};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ramp = 0;
    logic        offset_corr_valid = 0, gain_upd_done = 0, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, self_offset_enable, nvm_prog_prep, gain_upd_start, irq;
    logic [15:0] sensor_x = 16'h0011, sensor_y = 16'h0222, sensor_z = 16'h3333, ox, oy, oz;
    logic [15:0] offset_corr_x = 16'h1234, offset_corr_y = 16'h0abc, offset_corr_z = 16'hfed0;
    logic [10:0] grx, gry, grz;
    logic [7:0]  feat_int_status;
    int          mismatches = 0, comparisons = 0, cycles = 0, n;
    mfc_row_s    rows [12] = '{
        '{A_GEN, 16'h0124, 16'h0124, 16'hffef, 16'hffef, 16'hffef},
        '{A_GEN, 16'h00db, 16'h00db, 16'h0011, 16'h0222, 16'h3333},
        '{A_GEN, 16'h0052, 16'h0052, 16'h3333, 16'h3333, 16'h0222},
        '{A_GEN, 16'hffff, 16'h07ff, 16'hffef, 16'hfdde, 16'hcccd},
        '{A_GEN, 16'h0000, 16'h0000, 16'h0011, 16'h0011, 16'h0011},
        '{A_GEN, 16'h0088, 16'h0088, 16'h0011, 16'h0222, 16'h3333},
        '{A_GX,  16'hffff, 16'h07ff, 16'h0011, 16'h0222, 16'h3333},
        '{A_GX,  16'h0300, 16'h0300, 16'h0011, 16'h0222, 16'h3333},
        '{A_GY,  16'hf500, 16'h0500, 16'h0011, 16'h0222, 16'h3333},
        '{A_AM1, 16'h2002, 16'h2002, 16'h0011, 16'h0222, 16'h3333},
        '{A_AM2, 16'h9820, 16'h9820, 16'h0011, 16'h0222, 16'h3333},
        '{A_MK,  16'h0000, 16'h0000, 16'h0011, 16'h0222, 16'h3333}};
    logic [31:0] rst_a [6] = '{A_GEN, A_GX, A_GY, A_GZ, A_AM1, A_AM2};
    logic [15:0] rst_v [6] = '{16'h0088, 16'h0000, 16'h0000, 16'h0000, 16'he005, 16'h38aa};

    mfc_feature_page #(.SAMPLE_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sensor_x(sensor_x), .sensor_y(sensor_y), .sensor_z(sensor_z), .axis_out_x(ox),
        .axis_out_y(oy), .axis_out_z(oz), .offset_corr_valid(offset_corr_valid), .offset_corr_x(offset_corr_x),
        .offset_corr_y(offset_corr_y), .offset_corr_z(offset_corr_z), .self_offset_enable(self_offset_enable),
        .nvm_prog_prep(nvm_prog_prep), .gain_ratio_x(grx), .gain_ratio_y(gry), .gain_ratio_z(grz),
        .gain_upd_start(gain_upd_start), .gain_upd_done(gain_upd_done), .feat_int_status(feat_int_status), .irq(irq));

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (ramp) sensor_x <= sensor_x + 16'h0040;
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out;
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The request stays put until pready is seen high; the bench never assumes a latency.
    task automatic apb(input logic [31:0] a, input logic w, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].w);
            apb(rows[i].a, 1'b0, 16'h0);
            chk("readback", {16'h0, rows[i].r}, rd);
            chk("axes", {rows[i].ox, rows[i].oy}, {ox, oy});
            chk("axis z", rows[i].oz, oz);
            if (rows[i].a == A_GEN) chk("gen flags", rows[i].r[10:9], {nvm_prog_prep, self_offset_enable});
        end
        chk("ratios", {grx, gry}, {11'h300, 11'h500});
        apb(A_GZ, 1'b1, 16'h0c00);
        @(posedge pclk);
        chk("start", {grz, gain_upd_start}, {11'h400, 1'b1});
        gain_upd_done <= 1'b1;
        @(posedge pclk);
        gain_upd_done <= 1'b0;
        @(posedge pclk);
        chk("start clear", 1'b0, gain_upd_start);
        apb(A_GZ, 1'b0, 16'h0);
        chk("gain z word", 32'h0400, rd);
        apb(A_GEN, 1'b1, 16'h0288);
        offset_corr_valid <= 1'b1;
        @(posedge pclk);
        offset_corr_valid <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            apb(A_OX + 32'(k * 8), 1'b0, 16'h0);
            chk("offset", {16'h0, k == 0 ? offset_corr_x : k == 1 ? offset_corr_y : offset_corr_z}, rd);
        end
        chk("irq masked", 1'b0, irq);
        apb(A_MK, 1'b1, 16'h0004);
        @(posedge pclk);
        chk("irq raised", 1'b1, irq);
        apb(A_ST, 1'b1, 16'h0004);
        @(posedge pclk);
        chk("irq cleared", 1'b0, irq);
        ramp <= 1'b1;
        n = 0;
        while (feat_int_status === 8'h0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk("route", 8'h04, feat_int_status);
        ramp <= 1'b0;
        apb(A_ST, 1'b0, 16'h0);
        chk("status", 32'h3, rd);
        apb(32'h1fc, 1'b0, 16'h0);
        chk("unmapped", 32'h8000_0000, {er, rd[30:0]});
        apb(A_GEN + 32'h2, 1'b1, 16'h0000);
        chk("unaligned", 1'b1, er);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_a[i]) begin
            apb(rst_a[i], 1'b0, 16'h0);
            chk("reset value", {16'h0, rst_v[i]}, rd);
        end
        chk("reset outs", 3'b000, {irq, gain_upd_start, nvm_prog_prep});
        apb(A_OX, 1'b1, 16'h5a5a);
        offset_corr_valid <= 1'b1;
        @(posedge pclk);
        offset_corr_valid <= 1'b0;
        apb(A_OX, 1'b0, 16'h0);
        chk("host offset", 32'h5a5a, rd);
        close_out();
    end
endmodule
